// File: logic/upr_regs.sv
`timescale 1ns/1ps
module upr_regs #(
  parameter int NUM_PORTS = 4
) (
  input  wire logic                 clk_in,
  input  wire logic                 rst_b_in,
  input  wire logic                 por_b_in,
  input  wire logic                 acc_valid_in,
  input  wire logic                 acc_write_in,
  input  wire logic                 acc_runtime_in,
  input  wire logic [11:0]          acc_offset_in,
  input  wire logic [31:0]          acc_wdata_in,
  input  wire logic [NUM_PORTS-1:0] port_is_ss_in,
  input  wire logic [NUM_PORTS*3-1:0]  sleep_result_in,
  input  wire logic [NUM_PORTS*16-1:0] link_err_count_in,
  input  wire logic [7:0]           irq_event_in,
  output logic      [31:0]          acc_rdata_out,
  output logic                      acc_ack_out,
  output logic      [7:0]           irq_enable_out,
  output logic      [7:0]           irq_pending_out,
  output logic      [13:0]          microframe_counter_out
);
  typedef struct packed {
    logic [31:0]              rdata;
    logic                     ack;
    logic [7:0]               irq_enable;
    logic [7:0]               irq_pending;
    logic [7:0][31:0]         throttle;
    logic [13:0]              microframe_counter;
    logic [upr_pkg::MF_CNT_W-1:0] tick_cnt;
    logic [NUM_PORTS-1:0]     ss_meta;
    logic [NUM_PORTS-1:0]     ss_sync;
  } upr_regs_s;
  upr_regs_s r_ff, nxt_r;

  logic [NUM_PORTS-1:0]      pm_hit;
  logic [NUM_PORTS-1:0]      link_hit;
  logic [NUM_PORTS-1:0][31:0] pm_rd;
  logic [7:0]                ctrl_hit;
  logic [7:0]                thr_hit;
  logic [11:0]               ofs;

  // the runtime select marks accesses already offset from the runtime base
  assign ofs = acc_offset_in;

  // per-set and per-port address decode
  always_comb begin
    ctrl_hit = '0;
    thr_hit  = '0;
    pm_hit   = '0;
    link_hit = '0;
    for (int i = 0; i < upr_pkg::NUM_IRQ_SETS; i++) begin
      ctrl_hit[i] = acc_runtime_in
        && ofs == 12'(upr_pkg::RT_IRQ_CTRL_BASE + 12'(i) * upr_pkg::RT_SET_STRIDE);
      thr_hit[i]  = acc_runtime_in
        && ofs == 12'(upr_pkg::RT_IRQ_THR_BASE + 12'(i) * upr_pkg::RT_SET_STRIDE);
    end
    for (int p = 0; p < NUM_PORTS; p++) begin
      pm_hit[p]   = !acc_runtime_in
        && ofs == 12'(upr_pkg::OP_PM_BASE + 12'(p) * upr_pkg::OP_PORT_STRIDE);
      link_hit[p] = !acc_runtime_in
        && ofs == 12'(upr_pkg::OP_LINK_BASE + 12'(p) * upr_pkg::OP_PORT_STRIDE);
    end
  end

  // one slot per implemented port
  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
    upr_port_if pif ();
    assign pif.wr_pm = acc_valid_in && acc_write_in && pm_hit[g];
    assign pif.wdata = acc_wdata_in;
    assign pif.is_ss = r_ff.ss_sync[g];
    assign pm_rd[g]  = pif.pm_rdata;
    upr_port_slot u_slot (
      .clk_in          (clk_in),
      .rst_b_in        (rst_b_in),
      .por_b_in        (por_b_in),
      .sleep_result_in (sleep_result_in[g*3 +: 3]),
      .bus             (pif.slot)
    );
  end

  // next state: counter, interrupt bits, throttle, read data
  always_comb begin
    nxt_r = r_ff;
    nxt_r.ack = acc_valid_in;
    nxt_r.ss_meta = port_is_ss_in;
    nxt_r.ss_sync = r_ff.ss_meta;
    // microframe tick and counter, wraps naturally at 14 bits
    if (r_ff.tick_cnt == upr_pkg::MF_LAST) begin
      nxt_r.tick_cnt = '0;
      nxt_r.microframe_counter = r_ff.microframe_counter + 14'h0001;
    end else begin
      nxt_r.tick_cnt = r_ff.tick_cnt + upr_pkg::MF_CNT_W'(1);
    end
    // software access to interrupter sets
    for (int i = 0; i < upr_pkg::NUM_IRQ_SETS; i++) begin
      if (acc_valid_in && acc_write_in && ctrl_hit[i]) begin
        nxt_r.irq_enable[i] = acc_wdata_in[upr_pkg::IRQ_ENABLE_BIT];
      end
      if (acc_valid_in && !acc_write_in && ctrl_hit[i]) begin
        nxt_r.irq_pending[i] = 1'b0;
      end
      if (irq_event_in[i]) begin
        nxt_r.irq_pending[i] = 1'b1; // set wins over the read clear
      end
      if (acc_valid_in && acc_write_in && thr_hit[i]) begin
        nxt_r.throttle[i] = acc_wdata_in;
      end
    end
    // read mux; unmapped and reserved space reads zero
    nxt_r.rdata = '0;
    if (acc_valid_in && !acc_write_in) begin
      if (acc_runtime_in && ofs == upr_pkg::RT_MFINDEX_OFS) begin
        nxt_r.rdata[13:0] = r_ff.microframe_counter;
      end
      for (int i = 0; i < upr_pkg::NUM_IRQ_SETS; i++) begin
        if (ctrl_hit[i]) begin
          nxt_r.rdata[upr_pkg::IRQ_ENABLE_BIT]  = r_ff.irq_enable[i];
          nxt_r.rdata[upr_pkg::IRQ_PENDING_BIT] = r_ff.irq_pending[i];
        end
        if (thr_hit[i]) begin
          nxt_r.rdata = r_ff.throttle[i];
        end
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (pm_hit[p]) begin
          nxt_r.rdata = pm_rd[p];
        end
        if (link_hit[p] && r_ff.ss_sync[p]) begin
          nxt_r.rdata[15:0] = link_err_count_in[p*16 +: 16];
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      r_ff <= '0;
      r_ff.microframe_counter <= upr_pkg::MF_IDX_RST;
      for (int i = 0; i < upr_pkg::NUM_IRQ_SETS; i++) begin
        r_ff.throttle[i] <= upr_pkg::THROTTLE_RST;
      end
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign acc_rdata_out          = r_ff.rdata;
  assign acc_ack_out            = r_ff.ack;
  assign irq_enable_out         = r_ff.irq_enable;
  assign irq_pending_out        = r_ff.irq_pending;
  assign microframe_counter_out = r_ff.microframe_counter;
endmodule : upr_regs

// File: logic/upr_pkg.sv
package upr_pkg;
  // address spaces share one access port; a space select picks one of them
  localparam logic [11:0] OP_PM_BASE       = 12'h404;
  localparam logic [11:0] OP_LINK_BASE     = 12'h408;
  localparam logic [11:0] OP_PORT_STRIDE   = 12'h010;
  localparam logic [11:0] RT_MFINDEX_OFS   = 12'h000;
  localparam logic [11:0] RT_IRQ_CTRL_BASE = 12'h020;
  localparam logic [11:0] RT_IRQ_THR_BASE  = 12'h024;
  localparam logic [11:0] RT_SET_STRIDE    = 12'h020;
  localparam int          NUM_IRQ_SETS     = 8;
  localparam logic [31:0] THROTTLE_RST     = 32'h0000_0FA0;
  // field positions
  localparam int FORCE_ACCEPT_BIT = 16;
  localparam int U2_LSB           = 8;
  localparam int U1_LSB           = 0;
  localparam int TEST_CTRL_LSB    = 28;
  localparam int TARGET_SLOT_LSB  = 8;
  localparam int RESUME_DUR_LSB   = 4;
  localparam int WAKE_ALLOW_BIT   = 3;
  localparam int IRQ_ENABLE_BIT   = 1;
  localparam int IRQ_PENDING_BIT  = 0;
  // microframe tick timing
  localparam int CLK_PERIOD_NS    = 50;
  localparam int MICROFRAME_US    = 125;
  localparam int MICROFRAME_CYC   = (MICROFRAME_US * 1000) / CLK_PERIOD_NS;
  localparam int MF_CNT_W         = 12;
  localparam logic [MF_CNT_W-1:0] MF_LAST = MF_CNT_W'(MICROFRAME_CYC - 1);
  localparam logic [13:0] MF_IDX_RST = 14'h0000;
endpackage : upr_pkg

// File: logic/upr_port_if.sv
`timescale 1ns/1ps
// write strobe and data handed from the decoder to one port slot
interface upr_port_if;
  logic        wr_pm;
  logic [31:0] wdata;
  logic        is_ss;
  logic [31:0] pm_rdata;
  modport ctl  (output wr_pm, output wdata, output is_ss, input pm_rdata);
  modport slot (input wr_pm, input wdata, input is_ss, output pm_rdata);
endinterface : upr_port_if

// File: logic/upr_port_slot.sv
`timescale 1ns/1ps
// per-port power-management register, both layouts
module upr_port_slot (
  input  wire logic   clk_in,
  input  wire logic   rst_b_in,
  input  wire logic   por_b_in,
  input  wire logic [2:0] sleep_result_in,
  upr_port_if.slot    bus
);
  typedef struct packed {
    logic       force_lpm_accept;
    logic [3:0] test_ctrl;
    logic [7:0] slot_or_u2;
    logic [3:0] resume_drive_duration;
    logic       remote_wake_allow;
  } upr_slot_s;
  typedef struct packed {
    logic [7:0] u2_idle_limit;
    logic [7:0] u1_idle_limit;
  } upr_sticky_s;
  upr_slot_s   st_ff, nxt_st;
  upr_sticky_s sk_ff, nxt_sk;

  // field updates on a write strobe
  always_comb begin
    nxt_st = st_ff;
    nxt_sk = sk_ff;
    if (bus.wr_pm) begin
      if (bus.is_ss) begin
        nxt_st.force_lpm_accept = bus.wdata[upr_pkg::FORCE_ACCEPT_BIT];
        nxt_sk.u2_idle_limit    = bus.wdata[upr_pkg::U2_LSB +: 8];
        nxt_sk.u1_idle_limit    = bus.wdata[upr_pkg::U1_LSB +: 8];
      end else begin
        nxt_st.test_ctrl             = bus.wdata[upr_pkg::TEST_CTRL_LSB +: 4];
        nxt_st.slot_or_u2            = bus.wdata[upr_pkg::TARGET_SLOT_LSB +: 8];
        nxt_st.resume_drive_duration = bus.wdata[upr_pkg::RESUME_DUR_LSB +: 4];
        nxt_st.remote_wake_allow     = bus.wdata[upr_pkg::WAKE_ALLOW_BIT];
      end
    end
  end

  // ordinary state on the function reset
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // idle limits survive function reset, cleared by chip or power-on reset
  always_ff @(posedge clk_in or negedge por_b_in) begin
    if (!por_b_in) begin
      sk_ff <= '0;
    end else begin
      sk_ff <= nxt_sk;
    end
  end

  // read view, reserved bits zero
  always_comb begin
    bus.pm_rdata = '0;
    if (bus.is_ss) begin
      bus.pm_rdata[upr_pkg::FORCE_ACCEPT_BIT] = st_ff.force_lpm_accept;
      bus.pm_rdata[upr_pkg::U2_LSB +: 8]      = sk_ff.u2_idle_limit;
      bus.pm_rdata[upr_pkg::U1_LSB +: 8]      = sk_ff.u1_idle_limit;
    end else begin
      bus.pm_rdata[upr_pkg::TEST_CTRL_LSB +: 4]   = st_ff.test_ctrl;
      bus.pm_rdata[upr_pkg::TARGET_SLOT_LSB +: 8] = st_ff.slot_or_u2;
      bus.pm_rdata[upr_pkg::RESUME_DUR_LSB +: 4]  = st_ff.resume_drive_duration;
      bus.pm_rdata[upr_pkg::WAKE_ALLOW_BIT]       = st_ff.remote_wake_allow;
      bus.pm_rdata[2:0] = sleep_result_in;
    end
  end
endmodule : upr_port_slot

// File: test/upr_regs_properties.sv
`timescale 1ns/1ps
// watches host accesses, interrupt flags and the microframe counter
module upr_regs_chk (
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  input wire logic        acc_valid_in,
  input wire logic        acc_write_in,
  input wire logic        acc_runtime_in,
  input wire logic [11:0] acc_offset_in,
  input wire logic [31:0] acc_wdata_in,
  input wire logic [7:0]  irq_event_in,
  input wire logic [31:0] acc_rdata_out,
  input wire logic        acc_ack_out,
  input wire logic [7:0]  irq_enable_out,
  input wire logic [7:0]  irq_pending_out,
  input wire logic [13:0] microframe_counter_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  logic        rd0;
  logic        wr0;
  logic        moved;
  logic [13:0] mf_prev_ff;
  logic [11:0] gap_ff;
  // accesses to the set 0 control register
  assign rd0 = acc_valid_in && !acc_write_in && acc_runtime_in && acc_offset_in == 12'h020;
  assign wr0 = acc_valid_in && acc_write_in && acc_runtime_in && acc_offset_in == 12'h020;
  assign moved = microframe_counter_out != mf_prev_ff;
  // cycles since the counter last moved
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mf_prev_ff <= 14'h0000;
      gap_ff     <= 12'h000;
    end else begin
      mf_prev_ff <= microframe_counter_out;
      gap_ff     <= moved ? 12'h001 : gap_ff + 12'h001;
    end
  end
  a_ack_timing: assert property (acc_ack_out == $past(acc_valid_in))
    else $error("ack not one cycle after request");
  a_mf_period: assert property (moved |-> gap_ff == 12'd2500)
    else $error("counter moved off the tick");
  a_mf_advance: assert property (gap_ff <= 12'd2500)
    else $error("counter missed a tick");
  a_mf_step: assert property (moved |-> microframe_counter_out == mf_prev_ff + 14'h0001)
    else $error("counter step not one");
  a_en_write: assert property (wr0 |=> irq_enable_out[0] == $past(acc_wdata_in[1]))
    else $error("enable not written");
  a_pend_set: assert property (irq_event_in[0] |=> irq_pending_out[0])
    else $error("pending not set by event");
  a_pend_clear: assert property (rd0 && !irq_event_in[0] |=> !irq_pending_out[0])
    else $error("pending not cleared by read");
  a_pend_source: assert property (!irq_pending_out[0] && !irq_event_in[0] |=> !irq_pending_out[0])
    else $error("pending rose without event");
  a_ctrl_rsvd: assert property (rd0 |=> acc_rdata_out[31:2] == 30'h0)
    else $error("control reserved bits not zero");
endmodule : upr_regs_chk
bind upr_regs upr_regs_chk u_upr_regs_chk (.*);

// File: test/tb.sv
`timescale 1ns/1ps
// host-side bench for the port and runtime register slice
module tb;
  logic        clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        por_b_in = 1'b0;
  logic        acc_valid_in = 1'b0;
  logic        acc_write_in = 1'b0;
  logic        acc_runtime_in = 1'b0;
  logic [11:0] acc_offset_in = 12'h000;
  logic [31:0] acc_wdata_in = 32'h0000_0000;
  logic [3:0]  port_is_ss_in = 4'hA; // ports 1 and 3 superspeed
  logic [11:0] sleep_result_in = 12'h005;
  logic [63:0] link_err_count_in = 64'h1234_5678_BEEF_1111; // port 2 count must stay hidden
  logic [7:0]  irq_event_in = 8'h00;
  logic [31:0] acc_rdata_out;
  logic        acc_ack_out;
  logic [7:0]  irq_enable_out;
  logic [7:0]  irq_pending_out;
  logic [13:0] microframe_counter_out;
  logic [31:0] rd;
  int          err_count = 0;
  int          tests_run = 0;
  upr_regs #(.NUM_PORTS(4)) u_upr_regs (.*);
  // clock and watchdog
  initial begin
    forever #25 clk_in = ~clk_in;
  end
  initial begin
    #(50 * 20000);
    err_count++;
    tally_and_finish();
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one access: taken at the next edge, answered one edge later
  task automatic acc(input logic wr, input logic rt, input logic [11:0] ofs,
                     input logic [31:0] wd);
    @(posedge clk_in);
    acc_valid_in   <= 1'b1;
    acc_write_in   <= wr;
    acc_runtime_in <= rt;
    acc_offset_in  <= ofs;
    acc_wdata_in   <= wd;
    @(posedge clk_in);
    acc_valid_in <= 1'b0;
    #1 rd = acc_rdata_out;
    check({31'h0, acc_ack_out}, 32'h1);
  endtask : acc
  task automatic do_reset(input logic full);
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    por_b_in <= ~full;
    repeat (20) @(posedge clk_in);
    rst_b_in <= 1'b1;
    por_b_in <= 1'b1;
    repeat (3) @(posedge clk_in);
  endtask : do_reset
  // reset values, reserved map space, throttle read/write per set
  task automatic t_runtime;
    acc(1'b0, 1'b1, 12'h000, 32'h0); check(rd, 32'h0);
    acc(1'b1, 1'b1, 12'h000, 32'hFFFF_FFFF);
    acc(1'b0, 1'b1, 12'h000, 32'h0); check(rd, 32'h0);
    acc(1'b0, 1'b1, 12'h010, 32'h0); check(rd, 32'h0);
    for (int i = 0; i < 8; i++) begin
      acc(1'b0, 1'b1, 12'h024 + 12'(i * 32), 32'h0); check(rd, 32'h0000_0FA0);
      acc(1'b0, 1'b1, 12'h020 + 12'(i * 32), 32'h0); check(rd, 32'h0);
      acc(1'b1, 1'b1, 12'h024 + 12'(i * 32), 32'hA5A5_0000 + 32'(i));
    end
    for (int i = 0; i < 8; i++) begin
      acc(1'b0, 1'b1, 12'h024 + 12'(i * 32), 32'h0); check(rd, 32'hA5A5_0000 + 32'(i));
    end
  endtask : t_runtime
  // both port layouts, link info and sticky idle limits
  task automatic t_ports;
    acc(1'b1, 1'b0, 12'h414, 32'hFFFF_FFFF);
    acc(1'b0, 1'b0, 12'h414, 32'h0); check(rd, 32'h0001_FFFF);
    acc(1'b1, 1'b0, 12'h404, 32'hFFFF_FFFF);
    acc(1'b0, 1'b0, 12'h404, 32'h0); check(rd, 32'hF000_FFFD);
    acc(1'b1, 1'b0, 12'h424, 32'hFFFF_FFFF);
    acc(1'b0, 1'b0, 12'h424, 32'h0); check(rd, 32'hF000_FFF8);
    acc(1'b1, 1'b0, 12'h434, 32'hFFFF_FFFF);
    acc(1'b0, 1'b0, 12'h434, 32'h0); check(rd, 32'h0001_FFFF);
    acc(1'b0, 1'b0, 12'h444, 32'h0); check(rd, 32'h0);
    acc(1'b1, 1'b0, 12'h418, 32'hFFFF_FFFF);
    acc(1'b0, 1'b0, 12'h418, 32'h0); check(rd, 32'h0000_BEEF);
    acc(1'b0, 1'b0, 12'h438, 32'h0); check(rd, 32'h0000_1234);
    acc(1'b0, 1'b0, 12'h408, 32'h0); check(rd, 32'h0);
    acc(1'b0, 1'b0, 12'h428, 32'h0); check(rd, 32'h0);
    do_reset(1'b0);
    acc(1'b0, 1'b0, 12'h414, 32'h0); check(rd, 32'h0000_FFFF);
    do_reset(1'b1);
    acc(1'b0, 1'b0, 12'h414, 32'h0); check(rd, 32'h0);
  endtask : t_ports
  // enable, pending set by event and cleared by read
  task automatic t_irq;
    acc(1'b1, 1'b1, 12'h020, 32'hFFFF_FFFF);
    acc(1'b1, 1'b1, 12'h060, 32'h3);
    check({24'h0, irq_enable_out}, 32'h05);
    // events raised and dropped on rising edges, flags read once settled
    @(posedge clk_in);
    irq_event_in <= 8'h05;
    @(posedge clk_in);
    irq_event_in <= 8'h00;
    #1 check({24'h0, irq_pending_out}, 32'h05);
    acc(1'b0, 1'b1, 12'h060, 32'h0); check(rd, 32'h3);
    acc(1'b0, 1'b1, 12'h060, 32'h0); check(rd, 32'h2);
    acc(1'b0, 1'b1, 12'h020, 32'h0); check(rd, 32'h3);
    check({24'h0, irq_pending_out}, 32'h00);
  endtask : t_irq
  // first microframe tick after reset
  task automatic t_frame;
    do_reset(1'b1);
    repeat (2500) @(posedge clk_in);
    acc(1'b0, 1'b1, 12'h000, 32'h0); check(rd, 32'h1);
    check({18'h0, microframe_counter_out}, 32'h1);
  endtask : t_frame
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  // main sequence
  initial begin
    do_reset(1'b1);
    t_runtime();
    t_ports();
    t_irq();
    t_frame();
    tally_and_finish();
  end
endmodule : tb
